// >>> hdl/eth_evt_consts.svh
`ifndef ETH_EVT_CONSTS_SVH
`define ETH_EVT_CONSTS_SVH

// Register byte offsets
`define OFS_EVT_FLAGS   6'h00
`define OFS_EVT_SET     6'h04
`define OFS_EVT_CLR     6'h08
`define OFS_EVT_INV     6'h0c
`define OFS_MCOL_COUNT  6'h10
`define OFS_IRQ_STATUS  6'h14
`define OFS_IRQ_CLEAR   6'h18
`define OFS_IRQ_ENABLE  6'h1c
`define OFS_BUF_CTRL    6'h20
`define OFS_BUF_COUNT   6'h24

// Event flag bit positions
`define BIT_RX_DONE     7
`define BIT_PKT_WAIT    6
`define BIT_RX_ACT      5
`define BIT_UNUSED      4
`define BIT_TX_DONE     3
`define BIT_TX_ABORT    2
`define BIT_RX_DESC_NA  1
`define BIT_RX_OVFLW    0

// Clearable flags and implemented mask
`define EVT_CLR_MASK    8'haf
`define EVT_IMPL_MASK   8'hef

// Buffer control: decrement bit
`define BIT_BUF_DEC     0

// Interrupt status bits
`define IRQ_EVT_BIT     0
`define IRQ_MCOL_WRAP   1

`define MCOL_RESET      16'h0000
`endif

// >>> hdl/eth_evt_pkg.sv
package eth_evt_pkg;
   // Hardware event strobes, one cycle each
   typedef struct packed {
      logic rx_done;
      logic rx_data;
      logic tx_done;
      logic tx_abort;
      logic rx_desc_ovr;
      logic rx_fifo_ovf;
      logic rx_pkt_stored;
      logic tx_multi_col_ok;
   } hw_event_t;

   // Transmit status vector handed to the descriptor writer
   typedef struct packed {
      logic        valid;
      logic [31:0] vector;
   } tsv_store_t;

   // Complete block state
   typedef struct packed {
      logic [7:0]  flags;
      logic [15:0] mcol;
      logic [7:0]  received_buffer_counter;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_en;
      logic        ack;
      logic [31:0] rdata;
      logic        tsv_valid;
      logic [31:0] tsv_vector;
   } state_t;
endpackage

// >>> hdl/eth_evt_flags.sv
`timescale 1ns/100ps
`include "eth_evt_consts.svh"
module eth_evt_flags #(
   parameter int RECEIVED_BUFFER_COUNTER_W = 8
) (
   // Clock, reset, enable
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   // Wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [5:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   output logic                        wb_err_o,
   // Internal MAC and buffer manager events
   input  wire eth_evt_pkg::hw_event_t evt_i,
   input  wire logic [31:0]            tsv_i,
   output eth_evt_pkg::tsv_store_t     tsv_store_o,
   // Event and interrupt outputs
   output logic                        event_o,
   output logic                        irq_o
);
   import eth_evt_pkg::*;

   state_t s_r;
   state_t s_nxt;
   logic   req;
   logic   wr;
   logic   rd;
   logic   lo_lanes;
   logic [31:0] wmask;
   logic [7:0]  flag_rd;

   // Byte-lane write mask
   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   // Merge write data under lanes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [31:0] m);
      merge = (old & ~m) | (dat & m);
   endfunction

   // One request per cycle; ack drops the cycle after it was given
   assign req      = wb_cyc_i & wb_stb_i & ~s_r.ack;
   assign wr       = req & wb_we_i;
   assign rd       = req & ~wb_we_i;
   assign lo_lanes = wb_sel_i[0] | wb_sel_i[1];
   assign wmask    = lane_mask(wb_sel_i);

   // Visible flag byte: bit 6 from counter, bit 4 zero
   always_comb begin
      flag_rd = s_r.flags & `EVT_IMPL_MASK;
      flag_rd[`BIT_PKT_WAIT] = (s_r.received_buffer_counter != '0);
   end

   // Next-state logic for the whole block
   always_comb begin
      logic [7:0]  hw_set;
      logic [7:0]  sw_clr;
      logic [7:0]  sw_set;
      logic [7:0]  sw_inv;
      logic        mcol_wrap;
      logic [15:0] mcol_tmp;
      logic [31:0] mcol_mrg;
      mcol_mrg  = 32'h0000_0000;
      hw_set    = 8'h00;
      sw_clr    = 8'h00;
      sw_set    = 8'h00;
      sw_inv    = 8'h00;
      mcol_wrap = 1'b0;
      mcol_tmp  = s_r.mcol;
      s_nxt     = s_r;
      s_nxt.ack       = req;
      s_nxt.tsv_valid = 1'b0;

      // Hardware set sources
      hw_set[`BIT_RX_DONE]    = evt_i.rx_done;
      hw_set[`BIT_RX_ACT]     = evt_i.rx_data;
      hw_set[`BIT_TX_DONE]    = evt_i.tx_done;
      hw_set[`BIT_TX_ABORT]   = evt_i.tx_abort;
      hw_set[`BIT_RX_DESC_NA] = evt_i.rx_desc_ovr;
      hw_set[`BIT_RX_OVFLW]   = evt_i.rx_fifo_ovf;

      // Status vector stored with transmit done
      if (evt_i.tx_done) begin
         s_nxt.tsv_valid  = 1'b1;
         s_nxt.tsv_vector = tsv_i;
      end

      // Alias writes on the low byte
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            `OFS_EVT_FLAGS: begin
               sw_clr = ~wb_dat_i[7:0];
               sw_set = wb_dat_i[7:0];
            end
            `OFS_EVT_SET: sw_set = wb_dat_i[7:0];
            `OFS_EVT_CLR: sw_clr = wb_dat_i[7:0];
            `OFS_EVT_INV: sw_inv = wb_dat_i[7:0];
            default: ;
         endcase
      end
      // Packet-waiting and unused bit ignore software
      sw_clr = sw_clr & `EVT_CLR_MASK;
      sw_set = sw_set & `EVT_CLR_MASK;
      sw_inv = sw_inv & `EVT_CLR_MASK;
      // Hardware set wins over a clear in the same cycle
      s_nxt.flags = (((s_r.flags ^ sw_inv) | sw_set) & ~sw_clr) | hw_set;
      s_nxt.flags = s_nxt.flags & `EVT_CLR_MASK;

      // Received buffer counter: increment and decrement
      if (evt_i.rx_pkt_stored && !(wr && wb_adr_i == `OFS_BUF_CTRL
            && wb_sel_i[0] && wb_dat_i[`BIT_BUF_DEC]
            && s_r.received_buffer_counter != '0)) begin
         if (s_r.received_buffer_counter != '1)
            s_nxt.received_buffer_counter = s_r.received_buffer_counter + 8'h01;
      end else if (!evt_i.rx_pkt_stored && wr
            && wb_adr_i == `OFS_BUF_CTRL && wb_sel_i[0]
            && wb_dat_i[`BIT_BUF_DEC] && s_r.received_buffer_counter != '0) begin
         s_nxt.received_buffer_counter = s_r.received_buffer_counter - 8'h01;
      end

      // Collision counter: write, read-clear, increment
      // A call result cannot be part-selected, so merge into a temporary
      if (wr && wb_adr_i == `OFS_MCOL_COUNT) begin
         mcol_mrg = merge({16'h0000, s_r.mcol}, wb_dat_i, wmask);
         mcol_tmp = mcol_mrg[15:0];
      end else if (rd && wb_adr_i == `OFS_MCOL_COUNT && lo_lanes)
         mcol_tmp = `MCOL_RESET;
      if (evt_i.tx_multi_col_ok) begin
         mcol_wrap = (mcol_tmp == 16'hffff);
         mcol_tmp  = mcol_tmp + 16'h0001;
      end
      s_nxt.mcol = mcol_tmp;

      // Interrupt status: set wins over clear
      if (wr && wb_adr_i == `OFS_IRQ_CLEAR && wb_sel_i[0])
         s_nxt.irq_stat = s_r.irq_stat & ~wb_dat_i[1:0];
      if (wr && wb_adr_i == `OFS_IRQ_ENABLE && wb_sel_i[0])
         s_nxt.irq_en = wb_dat_i[1:0];
      if (|hw_set)
         s_nxt.irq_stat[`IRQ_EVT_BIT] = 1'b1;
      if (mcol_wrap)
         s_nxt.irq_stat[`IRQ_MCOL_WRAP] = 1'b1;

      // Read data, registered
      s_nxt.rdata = 32'h0000_0000;
      if (rd) begin
         case (wb_adr_i)
            `OFS_EVT_FLAGS:  s_nxt.rdata = {24'h000000, flag_rd};
            `OFS_MCOL_COUNT: s_nxt.rdata = {16'h0000, s_r.mcol};
            `OFS_IRQ_STATUS: s_nxt.rdata = {30'h0, s_r.irq_stat};
            `OFS_IRQ_ENABLE: s_nxt.rdata = {30'h0, s_r.irq_en};
            `OFS_BUF_COUNT:  s_nxt.rdata = {24'h000000, s_r.received_buffer_counter};
            default:         s_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register, frozen while enable is low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign wb_dat_o    = s_r.rdata;
   assign wb_ack_o    = s_r.ack;
   assign wb_err_o    = 1'b0;
   assign tsv_store_o = '{valid: s_r.tsv_valid, vector: s_r.tsv_vector};
   assign event_o     = |flag_rd;
   assign irq_o       = |(s_r.irq_stat & s_r.irq_en);

   // Assertions
   a_bit4_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_rd[`BIT_UNUSED] == 1'b0)
      else $error("unused flag bit reads one");
   a_pend_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
      flag_rd[`BIT_PKT_WAIT] == (s_r.received_buffer_counter != '0))
      else $error("packet waiting flag wrong");
   a_rx_complete_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.rx_done |=> s_r.flags[`BIT_RX_DONE])
      else $error("rx done not set");
   a_rx_activity_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.rx_data |=> s_r.flags[`BIT_RX_ACT])
      else $error("rx activity not set");
   a_tx_complete_flag_tsv: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.tx_done |=> s_r.flags[`BIT_TX_DONE]
         && tsv_store_o.valid && tsv_store_o.vector == $past(tsv_i))
      else $error("tx done or vector missing");
   a_abort_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.tx_abort |=> s_r.flags[`BIT_TX_ABORT])
      else $error("tx abort not set");
   a_descna_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.rx_desc_ovr |=> s_r.flags[`BIT_RX_DESC_NA])
      else $error("descriptor flag not set");
   a_ovf_set: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.rx_fifo_ovf |=> s_r.flags[`BIT_RX_OVFLW])
      else $error("overflow flag not set");
   a_clr_alias: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && wb_adr_i == `OFS_EVT_CLR && wb_sel_i[0]
      && wb_dat_i[`BIT_RX_DONE] && !evt_i.rx_done
      |=> !s_r.flags[`BIT_RX_DONE])
      else $error("clear alias failed");
   a_mcol_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rd && wb_adr_i == `OFS_MCOL_COUNT
      |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000)
      else $error("count upper half nonzero");
   a_mcol_inc: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && evt_i.tx_multi_col_ok && !req
      |=> s_r.mcol == $past(s_r.mcol) + 16'h0001)
      else $error("collision count not incremented");
   a_mcol_rdclr: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rd && wb_adr_i == `OFS_MCOL_COUNT && lo_lanes
      && !evt_i.tx_multi_col_ok |=> s_r.mcol == 16'h0000)
      else $error("read did not clear count");
   a_event_out: assert property (@(posedge clk_i) disable iff (rst_i)
      event_o == |(s_r.flags | {1'b0, s_r.received_buffer_counter != '0, 6'h00}))
      else $error("event output mismatch");
   // Acknowledge is a single-cycle pulse while running
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   // Error response is never given
   a_err_low: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_err_o)
      else $error("error response raised");
   // Frozen enable keeps the flags where they were
   a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> s_r.flags == $past(s_r.flags))
      else $error("flags moved while enable low");
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`include "eth_evt_consts.svh"
module tb_top;
   import eth_evt_pkg::*;
   logic                clk_i, rst_i, ce_i;
   logic                wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
   logic [5:0]          wb_adr_i;
   logic [3:0]          wb_sel_i;
   logic [31:0]         wb_dat_i, wb_dat_o, tsv_i, rd_v, rnd;
   hw_event_t           evt_i;
   tsv_store_t          tsv_store_o;
   logic                event_o, irq_o;
   int                  err_total, comparisons, received_buffer_counter, mcol;
   logic [7:0]          flg;
   int ev_idx[6] = '{7, 6, 5, 4, 3, 2};
   int fl_bit[6] = '{7, 5, 3, 2, 1, 0};

   eth_evt_flags i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .evt_i(evt_i), .tsv_i(tsv_i), .tsv_store_o(tsv_store_o),
      .event_o(event_o), .irq_o(irq_o));

   // Free-running 25 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Classic single cycle; no latency assumed, only the bound cuts a hang
   task automatic bus(logic we, logic [5:0] a, logic [3:0] s,
                      logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) chk("ack", 32'h0, 32'h1);
      chk("err", {31'h0, wb_err_o}, 32'h0);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      #1;
   endtask

   task automatic wr(logic [5:0] a, logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, 4'hf, d, q);
   endtask

   // One-cycle hardware strobe
   task automatic pulse(hw_event_t e);
      @(posedge clk_i);
      evt_i <= e;
      @(posedge clk_i);
      evt_i <= '0;
      #1;
   endtask

   // Compare flag register and combined output against the model
   task automatic chk_flags();
      logic [7:0] v;
      v = flg | ((received_buffer_counter != 0) ? 8'h40 : 8'h00);
      bus(1'b0, `OFS_EVT_FLAGS, 4'hf, 32'h0, rd_v);
      chk("flags", rd_v, {24'h0, v});
      chk("event", {31'h0, event_o}, {31'h0, v != 0});
   endtask

   initial begin
      err_total = 0; comparisons = 0; received_buffer_counter = 0; mcol = 0; flg = 8'h00;
      rst_i = 1'b1; ce_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
      wb_we_i = 1'b0; wb_adr_i = 6'h00; wb_sel_i = 4'h0;
      wb_dat_i = 32'h0; evt_i = '0; tsv_i = 32'h0;
      rnd = $urandom(32'h971c);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_flags();
      // Every flag source, then a random clear through the alias
      for (int i = 0; i < 6; i++) begin
         pulse(hw_event_t'(8'h01 << ev_idx[i]));
         flg[fl_bit[i]] = 1'b1;
         chk_flags();
      end
      rnd = $urandom;
      wr(`OFS_EVT_CLR, rnd);
      flg = flg & ~rnd[7:0];
      chk_flags();
      // Direct write and set alias cannot touch bits 6 and 4
      wr(`OFS_EVT_FLAGS, 32'hff);
      flg = 8'haf;
      chk_flags();
      wr(`OFS_EVT_CLR, 32'hff);
      wr(`OFS_EVT_SET, 32'h50);
      flg = 8'h00;
      chk_flags();
      // Invert alias flips only the clearable bits
      wr(`OFS_EVT_INV, 32'h51);
      flg = 8'h01;
      chk_flags();
      wr(`OFS_EVT_CLR, 32'h01);
      flg = 8'h00;
      // Buffer counter drives packet-waiting until decremented to zero
      repeat (2) pulse(hw_event_t'(8'h02));
      received_buffer_counter = 2;
      wr(`OFS_EVT_CLR, 32'h40);
      chk_flags();
      wr(`OFS_BUF_CTRL, 32'h1);
      received_buffer_counter = 1;
      chk_flags();
      wr(`OFS_BUF_CTRL, 32'h1);
      received_buffer_counter = 0;
      chk_flags();
      bus(1'b0, `OFS_BUF_COUNT, 4'hf, 32'h0, rd_v);
      chk("received_buffer_counter", rd_v, received_buffer_counter);
      // Status vector lands the cycle after transmit done
      @(posedge clk_i);
      tsv_i <= $urandom;
      pulse(hw_event_t'(8'h20));
      chk("tsv", {31'h0, tsv_store_o.valid}, 32'h1);
      chk("tsvv", tsv_store_o.vector, tsv_i);
      flg[3] = 1'b1;
      // Collision count: increments, read-clear, lane-gated read
      repeat (3) pulse(hw_event_t'(8'h01));
      mcol = 3;
      bus(1'b0, `OFS_MCOL_COUNT, 4'hf, 32'h0, rd_v);
      chk("mcol", rd_v, mcol);
      mcol = 0;
      rnd = $urandom;
      wr(`OFS_MCOL_COUNT, rnd);
      mcol = rnd[15:0];
      bus(1'b0, `OFS_MCOL_COUNT, 4'hc, 32'h0, rd_v);
      chk("mcol_hi", rd_v, mcol);
      bus(1'b0, `OFS_MCOL_COUNT, 4'hf, 32'h0, rd_v);
      chk("mcol_rd", rd_v, mcol);
      bus(1'b0, `OFS_MCOL_COUNT, 4'hf, 32'h0, rd_v);
      chk("mcol_clr", rd_v, 32'h0);
      // Count wrap raises its status bit beside the event bit
      wr(`OFS_MCOL_COUNT, 32'hffff);
      pulse(hw_event_t'(8'h01));
      bus(1'b0, `OFS_IRQ_STATUS, 4'hf, 32'h0, rd_v);
      chk("irq_wrap", rd_v, 32'h3);
      // Interrupt: raise, mask, clear; unmapped address reads zero
      wr(`OFS_IRQ_CLEAR, 32'h3);
      wr(`OFS_IRQ_ENABLE, 32'h1);
      chk("irq0", {31'h0, irq_o}, 32'h0);
      pulse(hw_event_t'(8'h80));
      flg[7] = 1'b1;
      chk("irq1", {31'h0, irq_o}, 32'h1);
      bus(1'b0, `OFS_IRQ_STATUS, 4'hf, 32'h0, rd_v);
      chk("irq_stat", rd_v, 32'h1);
      wr(`OFS_IRQ_ENABLE, 32'h0);
      chk("irqm", {31'h0, irq_o}, 32'h0);
      wr(`OFS_IRQ_CLEAR, 32'h3);
      wr(`OFS_IRQ_ENABLE, 32'h1);
      chk("irqc", {31'h0, irq_o}, 32'h0);
      bus(1'b0, 6'h3c, 4'hf, 32'h0, rd_v);
      chk("unmapped", rd_v, 32'h0);
      // An abort while the enable is low is lost
      @(posedge clk_i);
      ce_i <= 1'b0;
      pulse(hw_event_t'(8'h10));
      @(posedge clk_i);
      ce_i <= 1'b1;
      chk_flags();
      print_verdict();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(40 * 20000);
      err_total++;
      print_verdict();
   end
endmodule
